/* ocas_pkg.sv */
// constants, state layout and reset value for the configuration loader and access security block
package ocas_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int CFG_BYTES = 8;
	localparam int BUF_BYTES = 32;
	localparam int CFG_AW = 4;
	localparam int TIMER_W = 28;

	// ****************************************************************
	// command address map (byte wide)
	// ****************************************************************
	localparam logic [6:0] ADDR_BATT_STAT = 7'h12;
	localparam logic [6:0] ADDR_SUB_LO = 7'h3E;
	localparam logic [6:0] ADDR_SUB_HI = 7'h3F;
	localparam logic [6:0] ADDR_BUF_FIRST = 7'h40;
	localparam logic [6:0] ADDR_BUF_LAST = 7'h5F;
	localparam logic [6:0] ADDR_CHKSUM = 7'h60;
	localparam logic [6:0] ADDR_LENGTH = 7'h61;
	localparam logic [6:0] ADDR_CFG_STAT = 7'h70;

	// ****************************************************************
	// subcommand codes
	// ****************************************************************
	localparam logic [15:0] SUB_RESET = 16'h0012;
	localparam logic [15:0] SUB_RESTRICT = 16'h0030;
	localparam logic [15:0] SUB_KEYS = 16'h0035;
	localparam logic [15:0] SUB_CFG_ENTER = 16'h0090;
	localparam logic [15:0] SUB_CFG_EXIT = 16'h0092;
	localparam logic [15:0] SUB_DM_ALL = 16'h4000;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int SEC_RESTRICT_BIT = 0;
	localparam int SEC_FREEZE_BIT = 1;
	localparam int SEC_PERM_BIT = 2;
	localparam int CFG_SEC_IDX = 0;
	localparam int CFG_KEY1_IDX = 1;
	localparam int CFG_KEY2_IDX = 3;
	localparam int STAT_ACC_LOW_BIT = 0;
	localparam int STAT_ACC_HIGH_BIT = 1;
	localparam logic [7:0] LEN_OVERHEAD = 8'h04;
	localparam logic [7:0] LEN_KEYS = 8'h08;
	localparam logic [7:0] LEN_DM = 8'h0C;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_HZ = 40000000;
	localparam int UNLOCK_WINDOW_S = 5;
	localparam int UNLOCK_WINDOW_CYC = UNLOCK_WINDOW_S * CLK_HZ;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		PH_LOAD = 2'b00,
		PH_CHECK = 2'b01,
		PH_RUN = 2'b10,
		PH_OFF = 2'b11
	} ocas_phase_type;

	typedef struct packed {
		ocas_phase_type phase;
		logic [CFG_AW-1:0] ld_idx;
		logic [7:0] ld_sum;
		logic [CFG_BYTES-1:0][7:0] cfg;
		logic [BUF_BYTES-1:0][7:0] xbuf;
		logic [7:0] sub_lo;
		logic [7:0] sub_hi;
		logic [7:0] chk;
		logic restricted;
		logic unlock_armed;
		logic [TIMER_W-1:0] unlock_timer;
		logic cfg_update;
		logic frozen;
		logic perm_locked;
		logic [7:0] rdata;
	} ocas_state_type;

	localparam ocas_state_type OCAS_RESET_STATE = '0;

endpackage

/* ocas_core.sv */
// otp default loader, signature check and access security state machine
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module ocas_core
	import ocas_pkg::*;
#(
	parameter int unsigned UNLOCK_WINDOW = UNLOCK_WINDOW_CYC
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// command register port
	input wire logic [6:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// one-time memory read port
	output logic [CFG_AW-1:0] otp_addr_o,
	input wire logic [7:0] otp_rdata_i,
	// power control
	input wire logic powered_off_mode_req_i,
	input wire logic wake_req_i,
	// status and working configuration
	output logic powered_off_mode_o,
	output logic operation_run_o,
	output logic unrestricted_access_state_o,
	output logic [CFG_BYTES*8-1:0] config_o
);

	// ****************************************************************
	// checksum over subcommand bytes and the first n buffer bytes
	// ****************************************************************
	function automatic logic [7:0] buf_checksum(input logic [7:0] lo, input logic [7:0] hi,
		input logic [BUF_BYTES-1:0][7:0] b, input logic [7:0] n);
		logic [7:0] sum;
		sum = lo + hi;
		for (int i = 0; i < BUF_BYTES; i++) begin
			if (i < int'(n)) begin
				sum = sum + b[i];
			end
		end
		return ~sum;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	ocas_state_type s_r;
	ocas_state_type s_nxt;
	logic [15:0] sub_word;
	logic [15:0] cur_sub;
	logic [15:0] key1;
	logic [15:0] key2;
	logic [4:0] buf_idx;
	logic [6:0] buf_off;
	logic [7:0] data_len;

	assign sub_word = {reg_wdata_i, s_r.sub_lo};
	assign cur_sub = {s_r.sub_hi, s_r.sub_lo};
	// keys held little endian in working config
	assign key1 = {s_r.cfg[CFG_KEY1_IDX+1], s_r.cfg[CFG_KEY1_IDX]};
	assign key2 = {s_r.cfg[CFG_KEY2_IDX+1], s_r.cfg[CFG_KEY2_IDX]};
	assign buf_off = reg_addr_i - ADDR_BUF_FIRST;
	assign buf_idx = buf_off[4:0];
	assign data_len = reg_wdata_i - LEN_OVERHEAD;

	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = 8'h00;

		// unlock window runs down independently of bus activity
		if (s_r.unlock_armed) begin
			if (s_r.unlock_timer == '0) begin
				s_nxt.unlock_armed = 1'b0;
			end else begin
				s_nxt.unlock_timer = s_r.unlock_timer - 1'b1;
			end
		end

		case (s_r.phase)
			PH_LOAD: begin
				s_nxt.cfg[s_r.ld_idx[2:0]] = otp_rdata_i;
				s_nxt.ld_sum = s_r.ld_sum + otp_rdata_i;
				s_nxt.ld_idx = s_r.ld_idx + 1'b1;
				if (s_r.ld_idx == CFG_AW'(CFG_BYTES - 1)) begin
					s_nxt.phase = PH_CHECK;
				end
			end
			PH_CHECK: begin
				if (~s_r.ld_sum == otp_rdata_i) begin
					s_nxt.phase = PH_RUN;
					// blank part has the option clear and starts unrestricted
					s_nxt.restricted = s_r.cfg[CFG_SEC_IDX][SEC_RESTRICT_BIT];
				end else begin
					s_nxt = OCAS_RESET_STATE;
					s_nxt.phase = PH_OFF;
				end
			end
			PH_RUN: begin
				if (powered_off_mode_req_i) begin
					// all working state is lost, next wake reloads
					s_nxt = OCAS_RESET_STATE;
					s_nxt.phase = PH_OFF;
				end else if (reg_wr_i) begin
					// any write outside the pair breaks a pending unlock
					if (reg_addr_i != ADDR_SUB_LO && reg_addr_i != ADDR_SUB_HI) begin
						s_nxt.unlock_armed = 1'b0;
					end
					if (reg_addr_i == ADDR_SUB_LO) begin
						s_nxt.sub_lo = reg_wdata_i;
					end else if (reg_addr_i == ADDR_SUB_HI) begin
						s_nxt.sub_hi = reg_wdata_i;
						if (s_r.restricted) begin
							// only the key sequence is honoured while restricted
							if (s_r.perm_locked) begin
								s_nxt.unlock_armed = 1'b0;
							end else if (s_r.unlock_armed && sub_word == key2) begin
								s_nxt.restricted = 1'b0;
								s_nxt.unlock_armed = 1'b0;
							end else if (!s_r.unlock_armed && sub_word == key1) begin
								s_nxt.unlock_armed = 1'b1;
								s_nxt.unlock_timer = TIMER_W'(UNLOCK_WINDOW);
							end else begin
								s_nxt.unlock_armed = 1'b0;
							end
						end else begin
							case (sub_word)
								SUB_RESET: begin
									// working-only options vanish with the reload
									s_nxt = OCAS_RESET_STATE;
								end
								SUB_RESTRICT: begin
									s_nxt.restricted = 1'b1;
									s_nxt.perm_locked = s_r.cfg[CFG_SEC_IDX][SEC_PERM_BIT];
								end
								SUB_KEYS: begin
									s_nxt.xbuf[0] = s_r.cfg[CFG_KEY1_IDX];
									s_nxt.xbuf[1] = s_r.cfg[CFG_KEY1_IDX+1];
									s_nxt.xbuf[2] = s_r.cfg[CFG_KEY2_IDX];
									s_nxt.xbuf[3] = s_r.cfg[CFG_KEY2_IDX+1];
									s_nxt.chk = buf_checksum(s_r.sub_lo, reg_wdata_i, s_nxt.xbuf,
										LEN_KEYS - LEN_OVERHEAD);
								end
								SUB_CFG_ENTER: begin
									s_nxt.cfg_update = 1'b1;
								end
								SUB_CFG_EXIT: begin
									if (s_r.cfg_update) begin
										s_nxt.cfg_update = 1'b0;
										s_nxt.frozen = s_r.frozen | s_r.cfg[CFG_SEC_IDX][SEC_FREEZE_BIT];
									end
								end
								SUB_DM_ALL: begin
									for (int i = 0; i < CFG_BYTES; i++) begin
										s_nxt.xbuf[i] = s_r.cfg[i];
									end
									s_nxt.chk = buf_checksum(s_r.sub_lo, reg_wdata_i, s_nxt.xbuf,
										LEN_DM - LEN_OVERHEAD);
								end
								default: begin
								end
							endcase
						end
					end else if (reg_addr_i >= ADDR_BUF_FIRST && reg_addr_i <= ADDR_BUF_LAST) begin
						if (!s_r.restricted) begin
							s_nxt.xbuf[buf_idx] = reg_wdata_i;
						end
					end else if (reg_addr_i == ADDR_CHKSUM) begin
						s_nxt.chk = reg_wdata_i;
					end else if (reg_addr_i == ADDR_LENGTH) begin
						// length write commits the buffer when checksum agrees
						if (!s_r.restricted && !s_r.frozen && reg_wdata_i >= LEN_OVERHEAD
							&& s_r.chk == buf_checksum(s_r.sub_lo, s_r.sub_hi, s_r.xbuf, data_len)) begin
							if (cur_sub == SUB_KEYS && reg_wdata_i == LEN_KEYS) begin
								s_nxt.cfg[CFG_KEY1_IDX] = s_r.xbuf[0];
								s_nxt.cfg[CFG_KEY1_IDX+1] = s_r.xbuf[1];
								s_nxt.cfg[CFG_KEY2_IDX] = s_r.xbuf[2];
								s_nxt.cfg[CFG_KEY2_IDX+1] = s_r.xbuf[3];
							end else if (cur_sub == SUB_DM_ALL && reg_wdata_i == LEN_DM && s_r.cfg_update) begin
								for (int i = 0; i < CFG_BYTES; i++) begin
									s_nxt.cfg[i] = s_r.xbuf[i];
								end
							end
						end
					end
				end
			end
			PH_OFF: begin
				if (wake_req_i) begin
					s_nxt = OCAS_RESET_STATE;
				end
			end
			default: begin
				s_nxt = OCAS_RESET_STATE;
			end
		endcase

		// ****************************************************************
		// read path, answered in the following cycle
		// ****************************************************************
		if (reg_rd_i) begin
			if (reg_addr_i == ADDR_BATT_STAT) begin
				// readable in every state and lock condition
				s_nxt.rdata[STAT_ACC_LOW_BIT] = (s_r.phase == PH_RUN);
				s_nxt.rdata[STAT_ACC_HIGH_BIT] = (s_r.phase == PH_RUN) && s_r.restricted;
			end else if (reg_addr_i == ADDR_SUB_LO) begin
				s_nxt.rdata = s_r.sub_lo;
			end else if (reg_addr_i == ADDR_SUB_HI) begin
				s_nxt.rdata = s_r.sub_hi;
			end else if (reg_addr_i >= ADDR_BUF_FIRST && reg_addr_i <= ADDR_BUF_LAST) begin
				// stale buffer contents must not leak once restricted
				if (!s_r.restricted) begin
					s_nxt.rdata = s_r.xbuf[buf_idx];
				end
			end else if (reg_addr_i == ADDR_CHKSUM) begin
				s_nxt.rdata = s_r.chk;
			end else if (reg_addr_i == ADDR_CFG_STAT) begin
				s_nxt.rdata = {4'h0, s_r.cfg_update, s_r.frozen, s_r.perm_locked,
					s_r.phase == PH_OFF};
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			s_r <= OCAS_RESET_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign reg_rdata_o = s_r.rdata;
	assign otp_addr_o = s_r.ld_idx;
	assign powered_off_mode_o = (s_r.phase == PH_OFF);
	assign operation_run_o = (s_r.phase == PH_RUN) && !s_r.cfg_update;
	assign unrestricted_access_state_o = (s_r.phase == PH_RUN) && !s_r.restricted;
	assign config_o = s_r.cfg;

endmodule

/* ocas_chk.sv */
// port assertions for the configuration loader and access security block
`timescale 1ns/1ps
module ocas_chk
	import ocas_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [6:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// power and status
	input wire logic powered_off_mode_req_i,
	input wire logic powered_off_mode_o,
	input wire logic operation_run_o,
	input wire logic unrestricted_access_state_o,
	input wire logic [CFG_BYTES*8-1:0] config_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// last low subcommand byte, so the restrict word can be recognised on the high write
	logic [7:0] lo_r;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			lo_r <= 8'h00;
		end else if (reg_wr_i && reg_addr_i == ADDR_SUB_LO) begin
			lo_r <= reg_wdata_i;
		end
	end
	chk_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside its cycle");
	chk_stat_code: assert property ($past(reg_rd_i && reg_addr_i == ADDR_BATT_STAT) |->
		reg_rdata_o[7:2] == 6'h00 && reg_rdata_o[1:0] != 2'b10) else $error("bad access code");
	chk_stat_full: assert property ($past(reg_rd_i && reg_addr_i == ADDR_BATT_STAT && unrestricted_access_state_o)
		|-> reg_rdata_o == 8'h01) else $error("full access code wrong");
	chk_reset_clear: assert property (disable iff (1'b0) !rst_n_i |=> config_o == '0 &&
		!unrestricted_access_state_o && !operation_run_o) else $error("reset did not clear");
	chk_load_wait: assert property ($rose(rst_n_i) |-> !operation_run_o [*8])
		else $error("running before load");
	chk_unlock_pair: assert property ($rose(unrestricted_access_state_o) && $past(operation_run_o) |->
		$past(reg_wr_i && reg_addr_i == ADDR_SUB_HI)) else $error("unlock without key write");
	chk_restrict_cmd: assert property (operation_run_o && unrestricted_access_state_o && reg_wr_i &&
		reg_addr_i == ADDR_SUB_HI && reg_wdata_i == 8'h00 && lo_r == 8'h30 |=> !unrestricted_access_state_o)
		else $error("restrict ignored");
	chk_powered_off_mode: assert property (operation_run_o && powered_off_mode_req_i |=> powered_off_mode_o)
		else $error("powered_off_mode ignored");
	chk_off_quiet: assert property (powered_off_mode_o |-> !operation_run_o && !unrestricted_access_state_o)
		else $error("active while off");
	chk_locked_cfg: assert property (!unrestricted_access_state_o && operation_run_o &&
		$past(!unrestricted_access_state_o && operation_run_o) |-> $stable(config_o)) else $error("config changed");
	cover property ($rose(unrestricted_access_state_o) && $past(operation_run_o));
	cover property ($fell(unrestricted_access_state_o) && operation_run_o);
	cover property ($rose(powered_off_mode_o));
	cover property ($fell(operation_run_o) && unrestricted_access_state_o);
endmodule
bind ocas_core ocas_chk ocas_chk_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.powered_off_mode_req_i(powered_off_mode_req_i), .powered_off_mode_o(powered_off_mode_o), .operation_run_o(operation_run_o),
	.unrestricted_access_state_o(unrestricted_access_state_o), .config_o(config_o));

/* ocas_otp_model.sv */
// one-time memory model: nine programmed bytes, asynchronous read
`timescale 1ns/1ps
module ocas_otp_model
	import ocas_pkg::*;
(
	// programmed contents, byte i at bits [8i+7:8i]
	input wire logic [71:0] image_i,
	// read port
	input wire logic [CFG_AW-1:0] otp_addr_i,
	output logic [7:0] otp_rdata_o
);
	// unused addresses give a changing pattern, never a stale byte
	always_comb begin
		if (otp_addr_i <= 4'h8) begin
			otp_rdata_o = image_i[otp_addr_i*8 +: 8];
		end else begin
			otp_rdata_o = 8'hA5 ^ {4'h0, otp_addr_i};
		end
	end
endmodule

/* test_otp_config_and_access_security.sv */
// self-checking bench for the configuration loader and access security block
`timescale 1ns/1ps
module test_otp_config_and_access_security;
	import ocas_pkg::*;
	localparam int WIN = 50;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [6:0] reg_addr_i = 7'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic powered_off_mode_req_i = 1'b0;
	logic wake_req_i = 1'b0;
	logic [7:0] reg_rdata_o, otp_rdata;
	logic [CFG_AW-1:0] otp_addr;
	logic powered_off_mode_o, operation_run_o, unrestricted_access_state_o;
	logic [63:0] config_o;
	logic [8:0][7:0] img = '0;
	logic [15:0] k1, k2;
	int n_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed = 32'h694f;
	ocas_core #(.UNLOCK_WINDOW(WIN)) ocas_core_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.otp_addr_o(otp_addr), .otp_rdata_i(otp_rdata), .powered_off_mode_req_i(powered_off_mode_req_i), .wake_req_i(wake_req_i),
		.powered_off_mode_o(powered_off_mode_o), .operation_run_o(operation_run_o),
		.unrestricted_access_state_o(unrestricted_access_state_o), .config_o(config_o));
	ocas_otp_model ocas_otp_model_i (.image_i(img), .otp_addr_i(otp_addr), .otp_rdata_o(otp_rdata));
	initial forever #12.5 clock_i = ~clock_i;
	// *****
	// tasks
	// *****
	task automatic conclude();
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			$display("ERROR cycle_limit expected %0d seen %0d", 3999, cycles);
			conclude();
		end
	end
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		#1;
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic [7:0] sig(input logic [8:0][7:0] m);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++) s += m[i];
		return ~s;
	endfunction
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_wr_i <= 1'b1;
		reg_rd_i <= 1'b0;
		reg_addr_i <= a;
		reg_wdata_i <= d;
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clock_i);
			reg_wr_i <= 1'b0;
			reg_rd_i <= 1'b0;
		end
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] v);
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask
	task automatic sub(input logic [15:0] c);
		wr(ADDR_SUB_LO, c[7:0]);
		wr(ADDR_SUB_HI, c[15:8]);
	endtask
	// checksum over both subcommand bytes and the first n buffer bytes
	function automatic logic [7:0] csum(input logic [15:0] c, input logic [63:0] d, input int n);
		logic [7:0] s;
		s = c[7:0] + c[15:8];
		for (int i = 0; i < n; i++) s += d[8*i +: 8];
		return ~s;
	endfunction
	task automatic dm_load(input logic [63:0] d);
		sub(SUB_DM_ALL);
		for (int i = 0; i < 8; i++) wr(ADDR_BUF_FIRST + 7'(i), d[8*i +: 8]);
		wr(ADDR_CHKSUM, csum(SUB_DM_ALL, d, 8));
		wr(ADDR_LENGTH, LEN_DM);
	endtask
	task automatic unl(input logic [15:0] a, input logic [15:0] b);
		sub(a);
		sub(b);
		idle(2);
	endtask
	task automatic boot(input logic [7:0] sec, input logic [7:0] bad);
		img[0] = sec;
		{img[2], img[1]} = k1;
		{img[4], img[3]} = k2;
		{img[7], img[6], img[5]} = 24'($random(seed));
		img[8] = sig(img) ^ bad;
		@(posedge clock_i);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		idle(12);
	endtask
	task automatic wake();
		@(posedge clock_i);
		wake_req_i <= 1'b1;
		@(posedge clock_i);
		wake_req_i <= 1'b0;
		idle(12);
	endtask
	// *****
	// main sequence
	// *****
	initial begin
		logic [7:0] v;
		logic [31:0] nk;
		logic [63:0] nc;
		k1 = 16'($random(seed));
		k2 = k1 ^ 16'h8001;
		boot(8'h00, 8'h00);
		check("config", config_o, img[7:0]);
		check("full_access", unrestricted_access_state_o, 1'b1);
		rd(ADDR_BATT_STAT, v);
		check("status", v, 8'h01);
		sub(SUB_RESTRICT);
		idle(2);
		check("restricted", unrestricted_access_state_o, 1'b0);
		rd(ADDR_BATT_STAT, v);
		check("status", v, 8'h03);
		sub(k1);
		wr(ADDR_BUF_FIRST, 8'h55);
		unl(k2, k2);
		check("interloper", unrestricted_access_state_o, 1'b0);
		unl(k1, k2 ^ 16'h0100);
		check("wrong_key", unrestricted_access_state_o, 1'b0);
		unl(k2, k1);
		check("swapped", unrestricted_access_state_o, 1'b0);
		// let the window armed by the swapped pair lapse first
		idle(WIN + 2);
		sub(k1);
		idle(WIN + 10);
		unl(k2, k2);
		check("late_key", unrestricted_access_state_o, 1'b0);
		unl(k1, k2);
		check("unlocked", unrestricted_access_state_o, 1'b1);
		check("config_kept", config_o, img[7:0]);
		$display("test access done");
		nk = $random(seed);
		nk[16] = ~nk[0];
		sub(SUB_KEYS);
		for (int i = 0; i < 4; i++) wr(ADDR_BUF_FIRST + 7'(i), nk[8*i +: 8]);
		wr(ADDR_CHKSUM, ~(8'h35 + nk[7:0] + nk[15:8] + nk[23:16] + nk[31:24]));
		wr(ADDR_LENGTH, LEN_KEYS);
		idle(3);
		check("keys", config_o[39:8], nk);
		sub(SUB_KEYS);
		idle(1);
		for (int i = 0; i < 4; i++) begin
			rd(ADDR_BUF_FIRST + 7'(i), v);
			check("key_byte", v, nk[8*i +: 8]);
		end
		sub(SUB_RESTRICT);
		rd(ADDR_BUF_FIRST, v);
		check("locked_buf", v, 8'h00);
		unl(nk[15:0], nk[31:16]);
		check("new_keys", unrestricted_access_state_o, 1'b1);
		sub(SUB_CFG_ENTER);
		idle(2);
		check("cfg_halt", {operation_run_o, unrestricted_access_state_o}, 2'b01);
		nc = {$random(seed), $random(seed)};
		// freeze option set in working registers only
		nc[7:0] = 8'h02;
		dm_load(nc);
		sub(SUB_CFG_EXIT);
		idle(2);
		check("cfg_new", config_o, nc);
		check("cfg_run", operation_run_o, 1'b1);
		rd(ADDR_CFG_STAT, v);
		check("frozen", v, 8'h04);
		sub(SUB_CFG_ENTER);
		dm_load(~nc);
		sub(SUB_CFG_EXIT);
		idle(2);
		check("cfg_frozen", config_o, nc);
		sub(SUB_RESET);
		idle(12);
		check("reload", config_o, img[7:0]);
		rd(ADDR_CFG_STAT, v);
		check("unfrozen", v, 8'h00);
		$display("test config done");
		$display("test keys done");
		@(posedge clock_i);
		powered_off_mode_req_i <= 1'b1;
		@(posedge clock_i);
		powered_off_mode_req_i <= 1'b0;
		idle(1);
		check("off", powered_off_mode_o, 1'b1);
		wake();
		check("restored", config_o, img[7:0]);
		check("restored_run", operation_run_o, 1'b1);
		boot(8'h01, 8'h00);
		check("powerup_restrict", {operation_run_o, unrestricted_access_state_o}, 2'b10);
		boot(8'h04, 8'h00);
		sub(SUB_RESTRICT);
		unl(k1, k2);
		check("perm", unrestricted_access_state_o, 1'b0);
		boot(8'h00, 8'h01);
		check("bad_sig", {powered_off_mode_o, operation_run_o}, 2'b10);
		img[8] = sig(img);
		wake();
		check("good_sig", {powered_off_mode_o, operation_run_o}, 2'b01);
		$display("test power done");
		conclude();
	end
endmodule
